// file: hdl/sig_defines.svh
// constants for the signaling channel preprocessor: register offsets,
// control memory codes, command nibbles, status bits and reset values.
// assumes inclusion by bare name from every design file that needs it.
`ifndef SIG_DEFINES_SVH
`define SIG_DEFINES_SVH

// register offsets on the plain register port
`define REG_MEM_DATA      4'h0
`define REG_MEM_ADDR      4'h1
`define REG_MEM_CMD       4'h2
`define REG_MEM_RDBACK    4'h3
`define REG_INT_STATUS    4'h4
`define REG_INT_CLEAR     4'h5
`define REG_INT_ENABLE    4'h6
`define REG_FIFO_POP      4'h7
`define REG_FIFO_STATUS   4'h8
`define REG_LOOK_PERIOD   4'h9
`define REG_MODE          4'hA
`define REG_MEM_RDCODE    4'hB

// control memory codes
`define CM_CODE_SIG       4'hA
`define CM_CODE_IDLE      4'hB

// command register upper nibbles
`define CMD_WRITE_NIB     4'h7
`define CMD_READ_NIB      4'h4

// address fields: direction in the top bit, odd/even in the lowest
`define ADDR_DIR_BIT      7
`define ADDR_ODD_BIT      0

// mode register fields
`define MODE_EIGHT_BIT    0
`define MODE_HANDSHAKE    1

// interrupt status bits
`define INT_SIG_CHANGE    0
`define INT_FIFO_OVF      1

// reset, idle and fill values
`define RST_LOOK_PERIOD   8'h01
`define RST_MODE          8'h01
`define RST_BYTE          8'h00
`define IDLE_BYTE         8'hFF
`define SIX_BIT_FILL      2'h3

`endif

// file: hdl/sig_pkg.sv
// types shared by the signaling channel preprocessor files.
// assumes sig_defines.svh supplies all numeric constants.
package sig_pkg;
   typedef logic [7:0] byte_t;
   typedef logic [3:0] code_t;
   typedef logic [3:0] reg_addr_t;

   // sequencer of control memory accesses
   typedef enum logic [3:0]
   {
      st_idle,
      st_host_wr,
      st_host_rd,
      st_host_rd_wait,
      st_dn_rd,
      st_dn_wait,
      st_up_rd_act,
      st_up_rd_stb,
      st_up_eval,
      st_up_wr_stb
   } seq_e;
endpackage

// file: hdl/control_memory.sv
// control memory: one write port, one read port, registered read data.
// assumes a single clock; read data stand one cycle after the read enable.
`timescale 1ns/10ps
module control_memory
#(
   parameter int ADDR_W = 8,
   parameter int DATA_W = 12
)
(
   // clock
   input  wire logic              mclk,
   // write port
   input  wire logic              we,
   input  wire logic [ADDR_W-1:0] waddr,
   input  wire logic [DATA_W-1:0] wdata,
   // read port
   input  wire logic              re,
   input  wire logic [ADDR_W-1:0] raddr,
   output logic      [DATA_W-1:0] rdata
);
   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

   initial
   begin
      if (ADDR_W < 1 || DATA_W < 1)
         $error("control_memory: bad width");
   end

   // no reset on the array: software initialises every location it uses
   always_ff @(posedge mclk)
   begin
      if (we)
         mem[waddr] <= wdata;
      if (re)
         rdata <= mem[raddr];
   end
endmodule

// file: hdl/change_address_fifo.sv
// change address fifo: timeslot addresses of validated signaling changes.
// assumes a single clock; a push into a full fifo is dropped and flagged.
`timescale 1ns/10ps
module change_address_fifo
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
)
(
   // clock and reset
   input  wire logic             mclk,
   input  wire logic             rst,
   // fill side
   input  wire logic             push,
   input  wire logic [WIDTH-1:0] push_data,
   output logic                  overflow,
   // drain side
   input  wire logic             pop,
   output logic      [WIDTH-1:0] head,
   output logic                  not_empty,
   output logic                  full
);
   localparam int PW = $clog2(DEPTH);

   logic [WIDTH-1:0] store [0:DEPTH-1];
   logic [PW-1:0]    wptr;
   logic [PW-1:0]    rptr;
   logic [PW:0]      count;
   logic [PW-1:0]    next_wptr;
   logic [PW-1:0]    next_rptr;
   logic [PW:0]      next_count;
   logic             do_push;
   logic             do_pop;

   initial
   begin
      if (DEPTH < 2 || (1 << PW) != DEPTH)
         $error("change_address_fifo: depth must be a power of two");
   end

   // pointer arithmetic; power-of-two depth lets pointers wrap naturally
   always_comb
   begin
      do_pop     = pop && (count != '0);
      do_push    = push && (count != (PW+1)'(DEPTH));
      next_wptr  = do_push ? wptr + 1'b1 : wptr;
      next_rptr  = do_pop ? rptr + 1'b1 : rptr;
      next_count = count + (PW+1)'(do_push) - (PW+1)'(do_pop);
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         wptr      <= '0;
         rptr      <= '0;
         count     <= '0;
         overflow  <= 1'b0;
         not_empty <= 1'b0;
         full      <= 1'b0;
      end
      else
      begin
         wptr      <= next_wptr;
         rptr      <= next_rptr;
         count     <= next_count;
         overflow  <= push && !do_push;
         not_empty <= next_count != '0;
         full      <= next_count == (PW+1)'(DEPTH);
      end
   end

   // storage and registered head word
   always_ff @(posedge mclk)
   begin
      if (do_push)
         store[wptr] <= push_data;
      head <= store[next_rptr];
   end
endmodule

// file: hdl/signaling_channel_preprocess.sv
// signaling channel preprocessor for timeslot pairs of the line interface.
// assumes line-side strobes come from logic on mclk, so they are not resynchronised,
// and that the line side spaces its slot strobes at least eight cycles apart.
// Functional notes
// - in the 8-bit scheme the even slot of a pair is an 8-bit feature control channel.
// - in the 8-bit scheme the odd slot of a pair is an 8-bit signaling channel.
// - the feature channel goes to the monitor/feature handler in its chosen protocol.
// - the host reads and writes the signaling field through the control memory.
// - each valid upstream change raises an interrupt and queues the slot address.
// - changes are validated by double last-look sampling with a programmable period.
// - 8-bit codes: down even 1010 with data, down odd 1011, up even/odd 1011 actual/stable.
// - address top bit picks upstream (1) or downstream (0), low bit odd (1) or even (0).
// - a command with upper nibble 0111 writes its low nibble code plus pending data.
// - the even upstream location keeps last frame's value; stable moves on validation.
// - a change of the stable value sets the line interface interrupt status flag.
`timescale 1ns/10ps
`include "sig_defines.svh"
module signaling_channel_preprocess
#(
   parameter int FIFO_DEPTH = 16
)
(
   // clock and reset
   input  wire logic              mclk,
   input  wire logic              rst,
   // register port
   input  wire sig_pkg::reg_addr_t reg_addr,
   input  wire sig_pkg::byte_t    reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output sig_pkg::byte_t         reg_rdata,
   output logic                   irq,
   // line interface, upstream slot strobe
   input  wire logic              frame_sync,
   input  wire logic              up_valid,
   input  wire logic [6:0]        up_slot,
   input  wire sig_pkg::byte_t    up_byte,
   // line interface, downstream slot request
   input  wire logic              dn_req,
   input  wire logic [6:0]        dn_slot,
   output logic                   dn_valid,
   output sig_pkg::byte_t         dn_byte,
   // monitor/feature handler
   input  wire sig_pkg::byte_t    mf_dn_byte,
   input  wire logic [1:0]        mf_dn_mrmx,
   output logic                   mf_up_valid,
   output sig_pkg::byte_t         mf_up_byte,
   output logic                   mf_handshake
);
   import sig_pkg::*;

   // register state
   byte_t       mem_data;
   byte_t       mem_addr;
   byte_t       rdback;
   code_t       rdcode;
   logic [1:0]  int_status;
   logic [1:0]  int_enable;
   byte_t       look_period;
   byte_t       mode;
   logic        cmd_pend;
   logic        cmd_is_wr;
   code_t       cmd_code;
   // sequencer state
   seq_e        state;
   logic        up_pend;
   logic [6:0]  up_slot_q;
   byte_t       up_byte_q;
   logic        dn_pend;
   logic [6:0]  dn_slot_q;
   logic [11:0] act_word;
   // last-look sampling
   byte_t       frame_cnt;
   logic        sample_frame;
   // next values
   seq_e        next_state;
   logic        next_up_pend;
   logic        next_dn_pend;
   logic        next_cmd_pend;
   logic [11:0] next_act_word;
   byte_t       next_rdback;
   code_t       next_rdcode;
   logic        next_dn_valid;
   byte_t       next_dn_byte;
   logic        next_mf_up_valid;
   byte_t       next_mf_up_byte;
   logic        next_change;
   // memory and fifo wiring
   logic        mem_we;
   logic [7:0]  mem_waddr;
   logic [11:0] mem_wdata;
   logic        mem_re;
   logic [7:0]  mem_raddr;
   logic [11:0] mem_q;
   logic        fifo_pop;
   byte_t       fifo_head;
   logic        fifo_ne;
   logic        fifo_full;
   logic        fifo_ovf;
   logic        eight_bit;
   byte_t       sig_new;
   byte_t       sig_mask;
   code_t       up_code;

   initial
   begin
      if (FIFO_DEPTH < 2)
         $error("signaling_channel_preprocess: fifo too shallow");
   end

   // builds a control memory address from direction and slot
   function automatic logic [7:0] cm_index(input logic up, input logic [6:0] slot);
      cm_index = {up, slot};
   endfunction

   control_memory #(.ADDR_W(8), .DATA_W(12)) u_cm
   (
      .mclk  (mclk),
      .we    (mem_we),
      .waddr (mem_waddr),
      .wdata (mem_wdata),
      .re    (mem_re),
      .raddr (mem_raddr),
      .rdata (mem_q)
   );

   change_address_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo
   (
      .mclk      (mclk),
      .rst       (rst),
      .push      (next_change),
      .push_data (cm_index(1'b1, up_slot_q)),
      .overflow  (fifo_ovf),
      .pop       (fifo_pop),
      .head      (fifo_head),
      .not_empty (fifo_ne),
      .full      (fifo_full)
   );

   assign eight_bit = mode[`MODE_EIGHT_BIT];
   assign fifo_pop  = reg_rd && reg_addr == `REG_FIFO_POP;

   // scheme dependent view of the upstream signaling bits
   always_comb
   begin
      sig_mask = eight_bit ? `IDLE_BYTE : {6'h3F, 2'h0};
      sig_new  = up_byte_q & sig_mask;
      up_code  = eight_bit ? `CM_CODE_IDLE : `CM_CODE_SIG;
   end

   // control memory sequencer: host write first, then upstream, downstream, host read
   always_comb
   begin
      next_state       = state;
      next_up_pend     = up_pend || (up_valid && up_slot[`ADDR_ODD_BIT]);
      next_dn_pend     = dn_pend || dn_req;
      next_cmd_pend    = cmd_pend;
      next_act_word    = act_word;
      next_rdback      = rdback;
      next_rdcode      = rdcode;
      next_dn_valid    = 1'b0;
      next_dn_byte     = dn_byte;
      next_mf_up_valid = 1'b0;
      next_mf_up_byte  = mf_up_byte;
      next_change      = 1'b0;
      mem_we           = 1'b0;
      mem_waddr        = mem_addr;
      mem_wdata        = {cmd_code, mem_data};
      mem_re           = 1'b0;
      mem_raddr        = mem_addr;
      // even upstream slot carries monitor or feature data straight to the handler
      if (up_valid && !up_slot[`ADDR_ODD_BIT])
      begin
         next_mf_up_valid = 1'b1;
         next_mf_up_byte  = up_byte;
      end
      unique case (state)
         st_idle:
         begin
            if (cmd_pend && cmd_is_wr)
               next_state = st_host_wr;
            else if (up_pend)
               next_state = st_up_rd_act;
            else if (dn_pend)
               next_state = st_dn_rd;
            else if (cmd_pend)
               next_state = st_host_rd;
         end
         st_host_wr:
         begin
            mem_we        = 1'b1;
            next_cmd_pend = 1'b0;
            next_state    = st_idle;
         end
         st_host_rd:
         begin
            mem_re        = 1'b1;
            next_cmd_pend = 1'b0;
            next_state    = st_host_rd_wait;
         end
         st_host_rd_wait:
         begin
            next_rdback = mem_q[7:0];
            next_rdcode = mem_q[11:8];
            next_state  = st_idle;
         end
         st_dn_rd:
         begin
            // signaling byte always lives in the downstream even location
            mem_re       = 1'b1;
            mem_raddr    = cm_index(1'b0, {dn_slot_q[6:1], 1'b0});
            next_dn_pend = 1'b0;
            next_state   = st_dn_wait;
         end
         st_dn_wait:
         begin
            next_dn_valid = 1'b1;
            if (!dn_slot_q[`ADDR_ODD_BIT])
               next_dn_byte = mf_dn_byte;
            else if (mem_q[11:8] != `CM_CODE_SIG)
               next_dn_byte = `IDLE_BYTE;
            else if (eight_bit)
               next_dn_byte = mem_q[7:0];
            else
               next_dn_byte = {mem_q[7:2], mf_dn_mrmx};
            next_state = st_idle;
         end
         st_up_rd_act:
         begin
            mem_re     = 1'b1;
            mem_raddr  = cm_index(1'b1, {up_slot_q[6:1], 1'b0});
            next_state = st_up_rd_stb;
         end
         st_up_rd_stb:
         begin
            mem_re        = 1'b1;
            mem_raddr     = cm_index(1'b1, up_slot_q);
            next_act_word = mem_q;
            next_state    = st_up_eval;
         end
         st_up_eval:
         begin
            // actual value follows every frame; code field kept as programmed
            mem_we       = act_word[11:8] == up_code;
            mem_waddr    = cm_index(1'b1, {up_slot_q[6:1], 1'b0});
            mem_wdata    = {act_word[11:8], sig_new};
            next_up_pend = 1'b0;
            next_state   = st_idle;
            // double last look: same value in two frames, on a sampling frame
            if (mem_q[11:8] == up_code && sample_frame
                && sig_new == (act_word[7:0] & sig_mask)
                && sig_new != (mem_q[7:0] & sig_mask))
               next_state = st_up_wr_stb;
         end
         st_up_wr_stb:
         begin
            mem_we      = 1'b1;
            mem_waddr   = cm_index(1'b1, up_slot_q);
            mem_wdata   = {up_code, sig_new};
            next_change = 1'b1;
            next_state  = st_idle;
         end
      endcase
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         state       <= st_idle;
         up_pend     <= 1'b0;
         dn_pend     <= 1'b0;
         act_word    <= '0;
         rdback      <= `RST_BYTE;
         rdcode      <= '0;
         dn_valid    <= 1'b0;
         dn_byte     <= `RST_BYTE;
         mf_up_valid <= 1'b0;
         mf_up_byte  <= `RST_BYTE;
         up_slot_q   <= '0;
         up_byte_q   <= `RST_BYTE;
         dn_slot_q   <= '0;
      end
      else
      begin
         state       <= next_state;
         up_pend     <= next_up_pend;
         dn_pend     <= next_dn_pend;
         act_word    <= next_act_word;
         rdback      <= next_rdback;
         rdcode      <= next_rdcode;
         dn_valid    <= next_dn_valid;
         dn_byte     <= next_dn_byte;
         mf_up_valid <= next_mf_up_valid;
         mf_up_byte  <= next_mf_up_byte;
         // a new strobe only lands while the previous one is done
         if (up_valid && up_slot[`ADDR_ODD_BIT] && !up_pend)
         begin
            up_slot_q <= up_slot;
            up_byte_q <= up_byte;
         end
         if (dn_req && !dn_pend)
            dn_slot_q <= dn_slot;
      end
   end

   // sampling period counter in frames; zero behaves as one
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         frame_cnt    <= `RST_BYTE;
         sample_frame <= 1'b0;
      end
      else if (frame_sync)
      begin
         if (frame_cnt + 8'h01 >= look_period)
         begin
            frame_cnt    <= `RST_BYTE;
            sample_frame <= 1'b1;
         end
         else
         begin
            frame_cnt    <= frame_cnt + 8'h01;
            sample_frame <= 1'b0;
         end
      end
   end

   // register file; status set wins over a clear in the same cycle
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         mem_data     <= `RST_BYTE;
         mem_addr     <= `RST_BYTE;
         cmd_pend     <= 1'b0;
         cmd_is_wr    <= 1'b0;
         cmd_code     <= '0;
         int_status   <= '0;
         int_enable   <= '0;
         look_period  <= `RST_LOOK_PERIOD;
         mode         <= `RST_MODE;
         mf_handshake <= 1'b0;
         irq          <= 1'b0;
         reg_rdata    <= `RST_BYTE;
      end
      else
      begin
         cmd_pend <= next_cmd_pend;
         if (reg_wr)
         begin
            unique case (reg_addr)
               `REG_MEM_DATA:    mem_data    <= reg_wdata;
               `REG_MEM_ADDR:    mem_addr    <= reg_wdata;
               `REG_INT_ENABLE:  int_enable  <= reg_wdata[1:0];
               `REG_LOOK_PERIOD: look_period <= reg_wdata;
               `REG_MODE:        mode        <= reg_wdata;
               default:          ;
            endcase
            // the command write is what triggers the memory update
            if (reg_addr == `REG_MEM_CMD && !next_cmd_pend
                && (reg_wdata[7:4] == `CMD_WRITE_NIB || reg_wdata[7:4] == `CMD_READ_NIB))
            begin
               cmd_pend  <= 1'b1;
               cmd_is_wr <= reg_wdata[7:4] == `CMD_WRITE_NIB;
               cmd_code  <= reg_wdata[3:0];
            end
         end
         int_status[`INT_SIG_CHANGE] <= next_change || (int_status[`INT_SIG_CHANGE]
            && !(reg_wr && reg_addr == `REG_INT_CLEAR && reg_wdata[`INT_SIG_CHANGE]));
         int_status[`INT_FIFO_OVF] <= fifo_ovf || (int_status[`INT_FIFO_OVF]
            && !(reg_wr && reg_addr == `REG_INT_CLEAR && reg_wdata[`INT_FIFO_OVF]));
         mf_handshake <= mode[`MODE_HANDSHAKE];
         irq          <= |(int_status & int_enable);
         reg_rdata    <= `RST_BYTE;
         if (reg_rd)
         begin
            unique case (reg_addr)
               `REG_MEM_DATA:    reg_rdata <= mem_data;
               `REG_MEM_ADDR:    reg_rdata <= mem_addr;
               `REG_MEM_CMD:     reg_rdata <= {7'h00, cmd_pend};
               `REG_MEM_RDBACK:  reg_rdata <= rdback;
               `REG_MEM_RDCODE:  reg_rdata <= {4'h0, rdcode};
               `REG_INT_STATUS:  reg_rdata <= {6'h00, int_status};
               `REG_INT_ENABLE:  reg_rdata <= {6'h00, int_enable};
               `REG_FIFO_POP:    reg_rdata <= fifo_ne ? fifo_head : `IDLE_BYTE;
               `REG_FIFO_STATUS: reg_rdata <= {6'h00, fifo_full, fifo_ne};
               `REG_LOOK_PERIOD: reg_rdata <= look_period;
               `REG_MODE:        reg_rdata <= mode;
               default:          reg_rdata <= `RST_BYTE;
            endcase
         end
      end
   end
endmodule

// file: verification/sig_port_props.sv
// port checker for the signaling channel preprocessor.
// assumes the line side spaces its strobes as the block asks.
`timescale 1ns/10ps
`include "sig_defines.svh"
module sig_port_props
(
   // clock and reset
   input wire logic              mclk,
   input wire logic              rst,
   // register port
   input wire sig_pkg::reg_addr_t reg_addr,
   input wire sig_pkg::byte_t    reg_wdata,
   input wire logic              reg_wr,
   input wire logic              reg_rd,
   input wire sig_pkg::byte_t    reg_rdata,
   input wire logic              irq,
   // line and handler side
   input wire logic              up_valid,
   input wire logic [6:0]        up_slot,
   input wire sig_pkg::byte_t    up_byte,
   input wire logic              dn_req,
   input wire logic              dn_valid,
   input wire sig_pkg::byte_t    dn_byte,
   input wire logic              mf_up_valid,
   input wire sig_pkg::byte_t    mf_up_byte,
   input wire logic              mf_handshake
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   // read data may only show in the slot after a read strobe
   rd_data_slot_a: assert property (reg_rdata != 8'h00 |-> $past(reg_rd))
      else $error("read data outside its slot");
   unmapped_rd_a: assert property (reg_rd && reg_addr > `REG_MEM_RDCODE |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   // even slot goes straight to the handler
   mf_pass_a: assert property (up_valid && !up_slot[0] |=> mf_up_valid && mf_up_byte == $past(up_byte))
      else $error("feature byte not passed");
   mf_source_a: assert property (mf_up_valid |-> $past(up_valid) && !$past(up_slot[0]))
      else $error("handler strobe without even slot");
   dn_answer_a: assert property (dn_req |-> ##[3:9] dn_valid)
      else $error("downstream answer late");
   dn_pulse_a: assert property (dn_valid |=> !dn_valid)
      else $error("downstream strobe too long");
   dn_hold_a: assert property (!dn_valid |-> $stable(dn_byte))
      else $error("downstream byte moved");
   mode_level_a: assert property (reg_wr && reg_addr == `REG_MODE |=> ##1 mf_handshake == $past(reg_wdata[1], 2))
      else $error("protocol select wrong");
   // masking all sources drops the level within two edges
   irq_mask_a: assert property (reg_wr && reg_addr == `REG_INT_ENABLE && reg_wdata == 8'h00 |=> ##1 !irq)
      else $error("masked interrupt still high");
endmodule
bind signaling_channel_preprocess sig_port_props props (.mclk, .rst, .reg_addr, .reg_wdata, .reg_wr,
   .reg_rd, .reg_rdata, .irq, .up_valid, .up_slot, .up_byte, .dn_req, .dn_valid, .dn_byte,
   .mf_up_valid, .mf_up_byte, .mf_handshake);

// file: verification/line_codec_model.sv
// codec filter model: frame pulses, upstream slot strobes, downstream fetches.
// assumes the bench calls one task at a time.
`timescale 1ns/10ps
module line_codec_model
(
   // clock
   input wire logic           mclk,
   // upstream strobes
   output logic               frame_sync,
   output logic               up_valid,
   output logic [6:0]         up_slot,
   output sig_pkg::byte_t     up_byte,
   // downstream fetches
   output logic               dn_req,
   output logic [6:0]         dn_slot,
   input wire logic           dn_valid,
   input wire sig_pkg::byte_t dn_byte
);
   // idle lines at time zero
   initial
   begin
      frame_sync = 1'b0;
      up_valid = 1'b0;
      dn_req = 1'b0;
      up_slot = 7'h00;
      up_byte = 8'h00;
      dn_slot = 7'h00;
   end
   // one slot byte; released byte shows its inverse so stale data is never read
   task strobe(input logic [6:0] s, input sig_pkg::byte_t b);
      @(posedge mclk);
      up_valid <= 1'b1;
      up_slot <= s;
      up_byte <= b;
      @(posedge mclk);
      up_valid <= 1'b0;
      up_byte <= ~b;
      repeat (12) @(posedge mclk);
   endtask
   // one frame carrying an even and an odd byte of a pair
   task frame(input logic [6:0] p, input sig_pkg::byte_t ev, od);
      @(posedge mclk);
      frame_sync <= 1'b1;
      @(posedge mclk);
      frame_sync <= 1'b0;
      strobe(p, ev);
      strobe(p | 7'h01, od);
   endtask
   // downstream fetch, bounded wait; a lost answer returns unknown
   task fetch(input logic [6:0] s, output sig_pkg::byte_t b);
      b = 8'hXX;
      @(posedge mclk);
      dn_req <= 1'b1;
      dn_slot <= s;
      @(posedge mclk);
      dn_req <= 1'b0;
      repeat (12)
      begin
         @(posedge mclk);
         #1;
         if (dn_valid === 1'b1) b = dn_byte;
      end
   endtask
endmodule

// file: verification/signaling_channel_preprocess_bench.sv
// self-checking bench for the signaling channel preprocessor.
// assumes the codec model paces every line-side strobe.
`timescale 1ns/10ps
`include "sig_defines.svh"
module signaling_channel_preprocess_bench;
   import sig_pkg::*;
   typedef struct {byte_t a; byte_t d; code_t c;} row_s;
   logic       mclk, rst, reg_wr, reg_rd, irq, frame_sync, up_valid;
   logic       dn_req, dn_valid, mf_up_valid, mf_handshake;
   logic [1:0] mf_dn_mrmx;
   logic [6:0] up_slot, dn_slot;
   reg_addr_t  reg_addr;
   byte_t      reg_wdata, reg_rdata, up_byte, dn_byte, mf_dn_byte, mf_up_byte, rv;
   int         fail_count, num_checks;
   // address, data, code of 8-bit and 6-bit pairs, downstream and upstream each, upstream preloaded with a value that the test frames then change
   row_s       rows [8] = '{'{8'h10, 8'h45, 4'hA}, '{8'h11, 8'h3C, 4'hB},
                            '{8'hB0, 8'hD6, 4'hB}, '{8'hB1, 8'hD6, 4'hB},
                            '{8'h08, 8'h47, 4'hA}, '{8'h09, 8'h00, 4'hB},
                            '{8'h88, 8'hDF, 4'hA}, '{8'h89, 8'hDF, 4'hA}};
   signaling_channel_preprocess dut (.mclk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .irq, .frame_sync, .up_valid, .up_slot, .up_byte, .dn_req, .dn_slot, .dn_valid,
      .dn_byte, .mf_dn_byte, .mf_dn_mrmx, .mf_up_valid, .mf_up_byte, .mf_handshake);
   line_codec_model lc (.mclk, .frame_sync, .up_valid, .up_slot, .up_byte, .dn_req, .dn_slot,
      .dn_valid, .dn_byte);
   initial
   begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   task stop_test;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task chk(input byte_t s, e);
      num_checks++;
      if (s !== e)
      begin
         fail_count++;
         $display("Error %0t: saw %h want %h", $time, s, e);
      end
   endtask
   task wr(input reg_addr_t a, input byte_t d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task rd(input reg_addr_t a);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 rv = reg_rdata;
   endtask
   task cm_idle;
      rd(`REG_MEM_CMD);
      for (int n = 0; n < 20 && rv[0] !== 1'b0; n++) rd(`REG_MEM_CMD);
      if (rv[0] !== 1'b0)
      begin
         fail_count++;
         stop_test;
      end
      repeat (2) @(posedge mclk);
   endtask
   // data first, address next, the command last since it triggers the write
   task cm_wr(input byte_t a, d, input code_t c);
      wr(`REG_MEM_DATA, d);
      wr(`REG_MEM_ADDR, a);
      wr(`REG_MEM_CMD, {4'h7, c});
      cm_idle;
   endtask
   task cm_chk(input byte_t a, d, input code_t c);
      wr(`REG_MEM_ADDR, a);
      wr(`REG_MEM_CMD, 8'h40);
      cm_idle;
      rd(`REG_MEM_RDBACK);
      chk(rv, d);
      rd(`REG_MEM_RDCODE);
      chk(rv, {4'h0, c});
   endtask
   // bound on the whole run
   initial
   begin
      repeat (60000) @(posedge mclk);
      fail_count++;
      stop_test;
   end
   initial
   begin
      {rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {1'b1, 2'h0, 4'h0, 8'h00};
      mf_dn_byte = 8'h5A;
      mf_dn_mrmx = 2'h3;
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      rd(`REG_MODE);
      chk(rv, `RST_MODE);
      rd(`REG_LOOK_PERIOD);
      chk(rv, `RST_LOOK_PERIOD);
      $display("reset test done");
      foreach (rows[i])
      begin
         cm_wr(rows[i].a, rows[i].d, rows[i].c);
         cm_chk(rows[i].a, rows[i].d, rows[i].c);
      end
      $display("memory table done");
      lc.fetch(7'h11, rv);
      chk(rv, 8'h45);
      lc.fetch(7'h10, rv);
      chk(rv, 8'h5A);
      $display("downstream test done");
      // one differing sample is not yet a change; the repeat confirms it
      wr(`REG_INT_ENABLE, 8'h01);
      lc.frame(7'h30, 8'h77, 8'h9C);
      chk({7'h00, irq}, 8'h00);
      lc.frame(7'h30, 8'h77, 8'h9C);
      chk({7'h00, irq}, 8'h01);
      rd(`REG_FIFO_POP);
      chk(rv, 8'hB1);
      rd(`REG_INT_STATUS);
      chk(rv, 8'h01);
      cm_chk(8'hB0, 8'h9C, 4'hB);
      cm_chk(8'hB1, 8'h9C, 4'hB);
      wr(`REG_INT_ENABLE, 8'h00);
      wr(`REG_INT_CLEAR, 8'h01);
      lc.frame(7'h30, 8'h77, 8'h9C);
      rd(`REG_INT_STATUS);
      chk(rv, 8'h00);
      rd(`REG_FIFO_STATUS);
      chk(rv, 8'h00);
      $display("upstream test done");
      // 6-bit scheme: handler bits replace the two low data bits downstream
      wr(`REG_MODE, 8'h00);
      mf_dn_mrmx <= 2'h1;
      lc.fetch(7'h09, rv);
      chk(rv, 8'h45);
      repeat (2) lc.frame(7'h08, 8'h12, 8'hCD);
      rd(`REG_FIFO_POP);
      chk(rv, 8'h89);
      cm_chk(8'h89, 8'hCC, 4'hA);
      $display("six bit test done");
      wr(`REG_MODE, 8'h03);
      repeat (3) @(posedge mclk);
      chk({7'h00, mf_handshake}, 8'h01);
      rd(4'hF);
      chk(rv, 8'h00);
      rst <= 1'b1;
      repeat (2) @(posedge mclk);
      chk({7'h00, mf_handshake}, 8'h00);
      rst <= 1'b0;
      $display("mode and reset test done");
      stop_test;
   end
endmodule
